// >>> hw/stc_defines.vh
// Shared constants for the temperature result client block
`ifndef STC_DEFINES_VH
`define STC_DEFINES_VH
// AHB register byte offsets
`define STC_AHB_CONFIG   8'h00
`define STC_AHB_CONSEC   8'h04
`define STC_AHB_FILTER   8'h08
`define STC_AHB_ADDRSEL  8'h0C
`define STC_AHB_STATUS   8'h10
// Two-wire register addresses
`define STC_SMB_RES_LAST 8'h09
`define STC_SMB_CONFIG   8'h22
`define STC_SMB_CONSEC   8'h26
`define STC_SMB_FILTER   8'h28
`define STC_BLK_TEMP_LO  8'h80
`define STC_BLK_TEMP_HI  8'h89
`define STC_BLK_STAT_LO  8'h90
`define STC_BLK_STAT_HI  8'h97
`define STC_PAST_END     8'hFF
// Field positions
`define STC_RANGE_BIT    2
`define STC_TMO_BIT      7
`define STC_BLOCK_BIT    7
// Reset values
`define STC_CONFIG_RST   8'h00
`define STC_CONSEC_RST   8'h70
`define STC_FILTER_RST   2'h0
`define STC_ADDRSEL_RST  3'h0
// Client addresses: fixed variants, then pull-up table 4.7k..33k
`define STC_ADDR_FIX1    7'h4C
`define STC_ADDR_FIX2    7'h4D
`define STC_ADDR_R4K7    7'h7C
`define STC_ADDR_R6K8    7'h5C
`define STC_ADDR_R10K    7'h4C
`define STC_ADDR_R15K    7'h6C
`define STC_ADDR_R22K    7'h1C
`define STC_ADDR_R33K    7'h3C
// Result coding
`define STC_CODE_DEF_MAX 11'h3FF
`define STC_CODE_EXT_MAX 11'h7FF
`define STC_EXT_OFFSET   14'h0200
`define STC_CHAN_EXT1    3'h1
// Timing
`define STC_CLK_HZ       100000000
`define STC_TMO_MS       30
`endif

// >>> hw/stc_filter.v
// Result coding, clamping and running-average filter for channel results
`timescale 1ns/1ps
`default_nettype none
`include "stc_defines.vh"
module stc_filter (
  input  wire        hclk,      // System clock
  input  wire        hresetn,   // Async reset, active low
  input  wire        in_valid,  // Raw measurement strobe
  input  wire [2:0]  in_chan,   // Channel, 0 internal, 1..4 external
  input  wire [12:0] in_temp,   // Signed temperature in 1/8 degree
  input  wire        range_ext, // Extended range selected
  input  wire [1:0]  filt_sel,  // Filter level code
  output reg         out_valid, // Coded result strobe
  output reg  [2:0]  out_chan,  // Channel of coded result
  output reg  [10:0] out_code   // Coded, filtered 11-bit result
);
  reg  [10:0] hist_q [0:7];
  reg         primed_q;
  reg  [10:0] code;
  reg  [10:0] avg;
  wire [13:0] ext_t;
  wire [12:0] sum4;
  wire [13:0] sum8;
  wire        is_f;
  integer     i;

  assign ext_t = {in_temp[12], in_temp} + `STC_EXT_OFFSET;
  always @* begin
    code = in_temp[10:0];
    if (range_ext) begin
      if (ext_t[13])
        code = 11'h000;
      else if (ext_t[12:11] != 2'b00)
        code = `STC_CODE_EXT_MAX;
      else
        code = ext_t[10:0];
    end else if (in_temp[12]) begin
      code = 11'h000;
    end else if (in_temp[11:10] != 2'b00) begin
      code = `STC_CODE_DEF_MAX;
    end
  end

  assign is_f = in_valid && (in_chan == `STC_CHAN_EXT1);
  assign sum4 = {2'b00, code} + {2'b00, hist_q[0]} + {2'b00, hist_q[1]}
              + {2'b00, hist_q[2]};
  assign sum8 = {1'b0, sum4} + {3'b000, hist_q[3]} + {3'b000, hist_q[4]}
              + {3'b000, hist_q[5]} + {3'b000, hist_q[6]};

  always @* begin
    case (filt_sel)
      2'd1, 2'd2: avg = sum4[12:2];
      2'd3:       avg = sum8[13:3];
      default:    avg = code;
    endcase
    if (!primed_q)
      avg = code;
  end

  // History shifts whatever the level, so a level change is seamless
  // preload on first sample
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primed_q  <= 1'b0;
      out_valid <= 1'b0;
      out_chan  <= 3'h0;
      out_code  <= 11'h000;
      for (i = 0; i < 8; i = i + 1)
        hist_q[i] <= 11'h000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_chan <= in_chan;
        out_code <= is_f ? avg : code;
      end
      if (is_f) begin
        primed_q <= 1'b1;
        for (i = 1; i < 8; i = i + 1)
          hist_q[i] <= primed_q ? hist_q[i-1] : code;
        hist_q[0] <= code;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/stc_client.v
// Two-wire client, result store and AHB-Lite register slave
//
// Overview of operation
// - Filter code 0 off, 1 or 2 light, 3 strong.
// - Light is mean of last four, strong mean of last eight.
// - Filter only first external channel, on the coded 11-bit value.
// - First sample after reset fills all filter history slots.
// - Limit logic sees the filtered value that is also stored.
// - Result high byte holds bits 10:3, low byte top three bits.
// - Default range unsigned eighths, clamped 0 to 127.875.
// - Extended range offset 64, clamped -64 to 191.875.
// - Host may stretch the clock; this client never drives it.
// - Data falling while clock high starts a transfer.
// - Data rising while clock high returns client to idle.
// - Address byte is seven address bits then direction bit.
// - Fixed variants answer 1001_100x or 1001_101x.
// - Pull-up variant picks one of six addresses from a table.
// - Client acknowledges its own address and every byte then received in the ninth clock.
// - Clock low 30 ms with time-out on resets the interface.
// - Time-out is off after reset until its enable bit is set.
// - Write byte, read byte and block read are supported.
// - Register address bit 7 selects block instead of single access.
// - Block regions 80h-89h results and 90h-97h status.
// - Block read sends count, then data; past end FFh, pointer held.
// - Send byte only loads pointer; receive byte reads there.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "stc_defines.vh"
module stc_client #(
  parameter TMO_W      = 22,
  parameter TMO_CYCLES = `STC_TMO_MS * (`STC_CLK_HZ / 1000)
) (
  input  wire        hclk,          // System clock, 100 MHz
  input  wire        hresetn,       // Async reset, active low
  input  wire        hsel,          // AHB slave select
  input  wire [31:0] haddr,         // AHB address
  input  wire [1:0]  htrans,        // AHB transfer type
  input  wire        hwrite,        // AHB write
  input  wire [2:0]  hsize,         // AHB size, word only
  input  wire [31:0] hwdata,        // AHB write data
  input  wire        hready,        // AHB bus ready
  output reg  [31:0] hrdata,        // AHB read data
  output wire        hreadyout,     // Never waits
  output wire        hresp,         // Always OKAY
  input  wire        bus_clock_pin, // Two-wire clock from host
  input  wire        sda_in,        // Data pin level
  output wire        sda_out,       // Data pin drive value, always low
  output reg         sda_oe_n,      // Data pin enable, low drives
  input  wire        meas_valid,    // Raw measurement strobe
  input  wire [2:0]  meas_chan,     // Measured channel
  input  wire [12:0] meas_temp,     // Signed eighths of a degree
  input  wire [63:0] status_bytes,  // Eight status bytes, byte 0 low
  output wire        result_valid,  // Coded result strobe
  output wire [2:0]  result_chan,   // Coded result channel
  output wire [10:0] result_code    // Filtered code for limit checks
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_WDAT = 3'd3;
  localparam ST_WACK = 3'd4;
  localparam ST_RDAT = 3'd5;
  localparam ST_RACK = 3'd6;

  reg  [7:0]  config_q;
  reg  [7:0]  consec_q;
  reg  [1:0]  filter_q;
  reg  [2:0]  addrsel_q;
  reg  [10:0] res_q [0:4];
  reg         scl_s1, scl_s2, scl_s3;
  reg         sda_s1, sda_s2, sda_s3;
  reg  [2:0]  state_q;
  reg  [3:0]  cnt_q;
  reg  [7:0]  sh_q;
  reg  [7:0]  tx_q;
  reg  [7:0]  ptr_q;
  reg         first_q;
  reg         cntph_q;
  reg         past_q;
  reg         acked_q;
  reg  [TMO_W-1:0] tmo_q;
  reg         ahb_wr_q;
  reg  [7:0]  ahb_a_q;
  reg  [7:0]  rd_byte;
  reg  [7:0]  blk_end;
  reg         in_blk;
  wire [6:0]  my_addr;
  wire        scl_rise, scl_fall, start, stop, tmo_hit, smb_wr, ahb_go;
  integer     i;

  ////////////////////////////////////////////////////////////////////////
  // Functions

  function [6:0] addr_decode;
    input [2:0] sel;
    begin
      case (sel)
        3'd0:    addr_decode = `STC_ADDR_FIX1;
        3'd1:    addr_decode = `STC_ADDR_FIX2;
        3'd2:    addr_decode = `STC_ADDR_R4K7;
        3'd3:    addr_decode = `STC_ADDR_R6K8;
        3'd4:    addr_decode = `STC_ADDR_R10K;
        3'd5:    addr_decode = `STC_ADDR_R15K;
        3'd6:    addr_decode = `STC_ADDR_R22K;
        default: addr_decode = `STC_ADDR_R33K;
      endcase
    end
  endfunction

  function [7:0] res_byte;
    input [10:0] r;
    input        lo;
    begin
      res_byte = lo ? {r[2:0], 5'b00000} : r[10:3];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Result path

  stc_filter u_filter (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (meas_valid),
    .in_chan   (meas_chan),
    .in_temp   (meas_temp),
    .range_ext (config_q[`STC_RANGE_BIT]),
    .filt_sel  (filter_q),
    .out_valid (result_valid),
    .out_chan  (result_chan),
    .out_code  (result_code)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 5; i = i + 1)
        res_q[i] <= 11'h000;
    end else if (result_valid && result_chan < 3'd5) begin
      res_q[result_chan] <= result_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus conditions

  // Third stage only feeds edge detection, never the first stage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= bus_clock_pin;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  assign my_addr = addr_decode(addrsel_q);
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Time-out counter

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tmo_q <= {TMO_W{1'b0}};
    else if (!consec_q[`STC_TMO_BIT] || scl_s2 || state_q == ST_IDLE)
      tmo_q <= {TMO_W{1'b0}};
    else if (!tmo_hit)
      tmo_q <= tmo_q + 1'b1;
  end
  assign tmo_hit = (tmo_q == TMO_CYCLES[TMO_W-1:0]);

  ////////////////////////////////////////////////////////////////////////
  // Read byte selection

  always @* begin
    in_blk  = 1'b0;
    blk_end = `STC_BLK_TEMP_HI;
    if (ptr_q >= `STC_BLK_TEMP_LO && ptr_q <= `STC_BLK_TEMP_HI) begin
      in_blk = 1'b1;
    end else if (ptr_q >= `STC_BLK_STAT_LO &&
                 ptr_q <= `STC_BLK_STAT_HI) begin
      in_blk  = 1'b1;
      blk_end = `STC_BLK_STAT_HI;
    end
  end

  always @* begin
    rd_byte = 8'h00;
    if (ptr_q[`STC_BLOCK_BIT] && cntph_q)
      rd_byte = in_blk ? blk_end - ptr_q + 8'h01 : 8'h00;
    else if (ptr_q[`STC_BLOCK_BIT] && (past_q || !in_blk))
      rd_byte = `STC_PAST_END;
    else if (ptr_q[`STC_BLOCK_BIT] && ptr_q[4])
      rd_byte = status_bytes[{ptr_q[2:0], 3'b000} +: 8];
    else if (ptr_q[`STC_BLOCK_BIT] || ptr_q <= `STC_SMB_RES_LAST)
      rd_byte = res_byte(res_q[ptr_q[3:1]], ptr_q[0]);
    else if (ptr_q == `STC_SMB_CONFIG)
      rd_byte = config_q;
    else if (ptr_q == `STC_SMB_CONSEC)
      rd_byte = consec_q;
    else if (ptr_q == `STC_SMB_FILTER)
      rd_byte = {6'b000000, filter_q};
  end

  ////////////////////////////////////////////////////////////////////////
  // Client state machine

  // Data bytes after the pointer byte write the addressed register
  assign smb_wr = (state_q == ST_WDAT) && scl_fall && (cnt_q == 4'd8)
                  && !first_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 4'd0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 8'h00;
      first_q  <= 1'b0;
      cntph_q  <= 1'b0;
      past_q   <= 1'b0;
      acked_q  <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (stop || tmo_hit) begin
      state_q  <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else if (start) begin
      state_q  <= ST_ADDR;
      cnt_q    <= 4'd0;
      sda_oe_n <= 1'b1;
    end else begin
      case (state_q)
        ST_ADDR, ST_WDAT: begin
          if (scl_rise && cnt_q != 4'd8) begin
            sh_q  <= {sh_q[6:0], sda_s2};
            cnt_q <= cnt_q + 4'd1;
          end else if (scl_fall && cnt_q == 4'd8) begin
            if (state_q == ST_ADDR && sh_q[7:1] == my_addr) begin
              sda_oe_n <= 1'b0;
              state_q  <= ST_AACK;
              first_q  <= ~sh_q[0];
              cntph_q  <= sh_q[0] & ptr_q[`STC_BLOCK_BIT];
              past_q   <= 1'b0;
            end else if (state_q == ST_ADDR) begin
              state_q <= ST_IDLE;
            end else begin
              sda_oe_n <= 1'b0;
              state_q  <= ST_WACK;
              first_q  <= 1'b0;
              if (first_q)
                ptr_q <= sh_q;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            cnt_q <= 4'd0;
            if (sh_q[0]) begin
              // read starts with first byte out
              tx_q     <= {rd_byte[6:0], 1'b0};
              sda_oe_n <= rd_byte[7];
              state_q  <= ST_RDAT;
            end else begin
              sda_oe_n <= 1'b1;
              state_q  <= ST_WDAT;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            cnt_q    <= 4'd0;
            state_q  <= ST_WDAT;
          end
        end
        ST_RDAT: begin
          if (scl_fall && cnt_q == 4'd7) begin
            sda_oe_n <= 1'b1;
            state_q  <= ST_RACK;
            acked_q  <= 1'b0;
          end else if (scl_fall) begin
            sda_oe_n <= tx_q[7];
            tx_q     <= {tx_q[6:0], 1'b0};
            cnt_q    <= cnt_q + 4'd1;
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s2) begin
            state_q <= ST_IDLE;
          end else if (scl_rise) begin
            acked_q <= 1'b1;
            // advance or hold at block end
            if (cntph_q)
              cntph_q <= 1'b0;
            else if (ptr_q[`STC_BLOCK_BIT] && in_blk && ptr_q == blk_end)
              past_q <= 1'b1;
            else if (ptr_q[`STC_BLOCK_BIT] && in_blk)
              ptr_q <= ptr_q + 8'h01;
          end else if (scl_fall && acked_q) begin
            tx_q     <= {rd_byte[6:0], 1'b0};
            sda_oe_n <= rd_byte[7];
            cnt_q    <= 4'd0;
            state_q  <= ST_RDAT;
          end
        end
        default: begin
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  // Zero wait states; read data is captured in the address phase,
  // so a read right after a write to the same word sees the old value
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ahb_go    = hsel && hready && htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr_q <= 1'b0;
      ahb_a_q  <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end else begin
      ahb_wr_q <= ahb_go && hwrite;
      if (ahb_go)
        ahb_a_q <= haddr[7:0];
      if (ahb_go && !hwrite) begin
        case (haddr[7:0])
          `STC_AHB_CONFIG:  hrdata <= {24'h00_0000, config_q};
          `STC_AHB_CONSEC:  hrdata <= {24'h00_0000, consec_q};
          `STC_AHB_FILTER:  hrdata <= {30'h0000_0000, filter_q};
          `STC_AHB_ADDRSEL: hrdata <= {29'h0000_0000, addrsel_q};
          `STC_AHB_STATUS:  hrdata <= {9'h000, my_addr, ptr_q,
                                       5'h00, state_q};
          default:          hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration is reachable from both ports; AHB wins a tie
  // time-out enable resets low
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_q  <= `STC_CONFIG_RST;
      consec_q  <= `STC_CONSEC_RST;
      filter_q  <= `STC_FILTER_RST;
      addrsel_q <= `STC_ADDRSEL_RST;
    end else if (ahb_wr_q) begin
      case (ahb_a_q)
        `STC_AHB_CONFIG:  config_q  <= hwdata[7:0];
        `STC_AHB_CONSEC:  consec_q  <= hwdata[7:0];
        `STC_AHB_FILTER:  filter_q  <= hwdata[1:0];
        `STC_AHB_ADDRSEL: addrsel_q <= hwdata[2:0];
        default:          config_q  <= config_q;
      endcase
    end else if (smb_wr) begin
      case (ptr_q)
        `STC_SMB_CONFIG: config_q <= sh_q;
        `STC_SMB_CONSEC: consec_q <= sh_q;
        `STC_SMB_FILTER: filter_q <= sh_q[1:0];
        default:         config_q <= config_q;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> tb/stc_client_props.sv
// Port checks for the two-wire temperature result client
`timescale 1ns/1ps
`default_nettype none
module stc_client_props (
  input wire logic        hclk,          // System clock
  input wire logic        hresetn,       // Async reset, active low
  input wire logic        hreadyout,     // Slave ready
  input wire logic        hresp,         // Slave response
  input wire logic        bus_clock_pin, // Link clock
  input wire logic        sda_in,        // Data level
  input wire logic        sda_out,       // Data drive value
  input wire logic        sda_oe_n,      // Data enable, low drives
  input wire logic        meas_valid,    // Raw strobe
  input wire logic [2:0]  meas_chan,     // Raw channel
  input wire logic [12:0] meas_temp,     // Raw eighths of a degree
  input wire logic        result_valid,  // Coded strobe
  input wire logic [2:0]  result_chan,   // Coded channel
  input wire logic [10:0] result_code    // Coded result
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Samples that bypass the filter, so the code follows the raw value
  wire               unf = meas_valid && (meas_chan != 3'h1);
  wire signed [12:0] t   = meas_temp;
  wire        [10:0] t11 = meas_temp[10:0];
  ////////////////////////////////////////////////////////////////////
  bus_ok_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  pull_low_a: assert property (!sda_oe_n |-> sda_out == 1'b0)
    else $error("data driven high");
  // Moving data while the clock is high would fake a start or stop
  oe_clk_low_a: assert property (
    $changed(sda_oe_n) |-> !bus_clock_pin)
    else $error("data changed with clock high");
  start_rel_a: assert property ($fell(sda_in) && bus_clock_pin &&
    $past(bus_clock_pin) |-> ##[1:6] sda_oe_n)
    else $error("data held at start");
  stop_idle_a: assert property ($rose(sda_in) && bus_clock_pin
    |=> sda_oe_n [*4])
    else $error("data driven after stop");
  res_pulse_a: assert property (meas_valid |=> result_valid &&
    result_chan == $past(meas_chan))
    else $error("result strobe or channel wrong");
  res_only_a: assert property (result_valid |-> $past(meas_valid))
    else $error("result without sample");
  raw_code_a: assert property (unf && t >= 0 && t < 1024 |=>
    result_code == $past(t11) || result_code == $past(t11) + 11'h200)
    else $error("unfiltered code wrong");
  clamp_low_a: assert property (unf && t < -512 |=>
    result_code == 11'h000)
    else $error("low clamp wrong");
  clamp_high_a: assert property (unf && t > 1535 |=>
    result_code == 11'h3FF || result_code == 11'h7FF)
    else $error("high clamp wrong");
endmodule
bind stc_client stc_client_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .bus_clock_pin(bus_clock_pin),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_temp(meas_temp),
  .result_valid(result_valid), .result_chan(result_chan),
  .result_code(result_code));
`default_nettype wire

// >>> tb/stc_host_model.sv
// Two-wire host controller model, link clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module stc_host_model (
  output logic      link_clk, // Link clock
  output logic      sda_low,  // Host pulls data low
  input  wire logic sda_wire  // Resolved data, pulled up
);
  // Idle bus
  initial begin
    link_clk <= 1'b1;
    sda_low <= 1'b0;
  end
  // stretch the low phase by st ns
  // Pins move by non-blocking assignment, so a change that lands on a
  // system clock edge is never raced by the client's first flip-flop
  task automatic bit_io(input logic b, input int st, output logic s);
    link_clk <= 1'b0;
    #31.25 sda_low <= !b;
    #(31.25 + st) link_clk <= 1'b1;
    #31.25 s = sda_wire;
    #31.25;
  endtask
  // data falls with clock high, also as repeated start
  task automatic start();
    link_clk <= 1'b0;
    #31.25 sda_low <= 1'b0;
    #31.25 link_clk <= 1'b1;
    #31.25 sda_low <= 1'b1;
    #31.25;
  endtask
  // Stop, then the clock stands high
  task automatic stop();
    link_clk <= 1'b0;
    #31.25 sda_low <= 1'b1;
    #31.25 link_clk <= 1'b1;
    #31.25 sda_low <= 1'b0;
    #62.5;
  endtask
  // Byte out MSB first, ack bit released and sampled
  task automatic wr_byte(input logic [7:0] v, input int st, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(v[i], 0, s);
    bit_io(1'b1, st, s);
    ack = !s;
  endtask
  // host acks all but the last byte
  task automatic rd_byte(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, 0, v[i]);
    bit_io(!ack, 0, s);
  endtask
  // Clock held low, as a stalled host would
  task automatic hold_low(input int dur);
    link_clk <= 1'b0;
    #dur link_clk <= 1'b1;
    #62.5;
  endtask
endmodule
`default_nettype wire

// >>> tb/stc_client_tb.sv
// Testbench for the temperature result client
`timescale 1ns/1ps
`default_nettype none
module stc_client_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        meas_valid = 1'b0;
  logic [2:0]  meas_chan = 3'h0;
  logic [12:0] meas_temp = 13'h0000;
  wire  [31:0] hrdata;
  wire         hrdy, hresp, sda_out, sda_oe_n, result_valid;
  wire  [2:0]  result_chan;
  wire  [10:0] result_code;
  wire         link_clk, sda_low, sda_wire;
  int          miscompares = 0;
  int          n_compared = 0;
  logic        k;
  logic [7:0]  d;
  logic [31:0] x;
  logic [63:0] tbl = 64'h4C4D_7C5C_4C6C_1C3C;
  always #5 hclk = ~hclk;
  // Pulled-up data wire, low when either side drives
  assign sda_wire = !((!sda_oe_n && !sda_out) || sda_low);
  stc_client #(.TMO_CYCLES(200)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .bus_clock_pin(link_clk),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_temp(meas_temp),
    .status_bytes(64'h8877_6655_4433_2211), .result_valid(result_valid),
    .result_chan(result_chan), .result_code(result_code));
  stc_host_model host (.link_clk(link_clk), .sda_low(sda_low),
    .sda_wire(sda_wire));
  ////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  // Bounded wait for the slave's ready
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
  endtask
  // One AHB-Lite single word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] y;
    ahb(1'b1, a, v, y);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] y;
    ahb(1'b0, a, 32'h0000_0000, y);
    chk("register", y, e);
  endtask
  // Raw sample in, coded result checked one cycle later
  task automatic meas(input logic [2:0] c, input logic [12:0] t,
                      input logic [10:0] e);
    @(posedge hclk);
    meas_valid <= 1'b1;
    meas_chan <= c;
    meas_temp <= t;
    @(posedge hclk);
    meas_valid <= 1'b0;
    #1 chk("result", 32'(result_code), 32'(e));
  endtask
  // Address with write, then register pointer
  task automatic addr_w(input logic [7:0] p);
    host.start();
    host.wr_byte(8'h98, 0, k);
    chk("addr_ack", 32'(k), 32'h1);
    host.wr_byte(p, 0, k);
    chk("ptr_ack", 32'(k), 32'h1);
  endtask
  task automatic smb_rd(input logic [7:0] p, input logic [7:0] e);
    addr_w(p);
    host.start();
    host.wr_byte(8'h99, 0, k);
    host.rd_byte(1'b0, d);
    chk("read_byte", 32'(d), 32'(e));
    host.stop();
  endtask
  // Count then four bytes, the last not acknowledged
  task automatic smb_blk(input logic [7:0] p, input logic [39:0] e);
    addr_w(p);
    host.start();
    host.wr_byte(8'h99, 0, k);
    for (int i = 0; i < 5; i++) begin
      host.rd_byte(i < 4, d);
      chk("block", 32'(d), 32'(e[39-8*i -: 8]));
    end
    host.stop();
  endtask
  // Stall the clock inside a frame, then look at the client state
  task automatic tmo(input logic [31:0] e);
    host.start();
    host.wr_byte(8'h98, 0, k);
    host.hold_low(3000);
    ahb(1'b0, 8'h10, 32'h0000_0000, x);
    chk("busy", 32'(x[2:0] != 3'h0), e);
    host.stop();
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0070);
    rd(8'h08, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    meas(3'h0, 13'h0209, 11'h209);
    smb_rd(8'h00, 8'h41);
    smb_rd(8'h01, 8'h20);
    meas(3'h2, 13'h1FF8, 11'h000);
    meas(3'h2, 13'h0410, 11'h3FF);
    wr(8'h00, 32'h0000_0004);
    meas(3'h3, 13'h1FF8, 11'h1F8);
    meas(3'h3, 13'h0640, 11'h7FF);
    meas(3'h3, 13'h1DA8, 11'h000);
    wr(8'h00, 32'h0000_0000);
    wr(8'h08, 32'h0000_0001);
    meas(3'h1, 13'h0050, 11'h050);
    meas(3'h1, 13'h00A0, 11'h064);
    addr_w(8'h28);
    host.wr_byte(8'h03, 0, k);
    chk("data_ack", 32'(k), 32'h1);
    host.stop();
    rd(8'h08, 32'h0000_0003);
    meas(3'h1, 13'h00A0, 11'h064);
    wr(8'h08, 32'h0000_0002);
    meas(3'h1, 13'h00A0, 11'h08C);
    wr(8'h08, 32'h0000_0000);
    meas(3'h1, 13'h0008, 11'h008);
    smb_rd(8'h02, 8'h01);
    meas(3'h4, 13'h03E8, 11'h3E8);
    smb_blk(8'h88, 40'h02_7D00_FFFF);
    smb_blk(8'h96, 40'h02_7788_FFFF);
    host.start();
    host.wr_byte(8'h98, 0, k);
    host.wr_byte(8'h00, 400, k);
    chk("send_ack", 32'(k), 32'h1);
    host.stop();
    host.start();
    host.wr_byte(8'h99, 0, k);
    host.rd_byte(1'b0, d);
    chk("receive", 32'(d), 32'h41);
    host.stop();
    for (int i = 0; i < 8; i++) begin
      wr(8'h0C, 32'(i));
      host.start();
      host.wr_byte({tbl[62-8*i -: 7], 1'b0}, 0, k);
      chk("sel_ack", 32'(k), 32'h1);
      host.stop();
    end
    host.start();
    host.wr_byte(8'h98, 0, k);
    chk("wrong_addr", 32'(k), 32'h0);
    host.stop();
    wr(8'h0C, 32'h0000_0000);
    tmo(32'h1);
    wr(8'h04, 32'h0000_00F0);
    tmo(32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
